// File: hw/pixel_readout_defines.vh
// Constants for the pixel array readout address generator
`ifndef PIXEL_READOUT_DEFINES_VH
`define PIXEL_READOUT_DEFINES_VH

// Video formats held in the format register
`define FMT_MID           2'h0
`define FMT_VGA           2'h1
`define FMT_QTR           2'h2
`define FMT_DEC           2'h3
`define FMT_RESET         2'h0

// Register indices; the byte address is four times the index
`define REG_FORMAT        8'h10
`define REG_READOUT_A     8'h11
`define REG_READOUT_B     8'h16
`define REG_XOFF_HI       8'h58
`define REG_XOFF_LO       8'h59
`define REG_YOFF_HI       8'h5a
`define REG_YOFF_LO       8'h5b
`define REG_LINE_LEN      8'h60
`define REG_FIELD_LEN     8'h61
`define REG_STATUS        8'h62

// Readout option bit positions
`define HSHUF_BIT         7
`define HMIRR_BIT         3
`define VSHUF_BIT         2
`define VMIRR_BIT         4
`define READOUT_A_RESET   8'h80
`define READOUT_B_RESET   8'h00

// Image sizes
`define VGA_W             10'h284
`define VGA_H             10'h1e4
`define QTR_W             10'h144
`define QTR_H             10'h0f4
`define MID_W             10'h164
`define MID_H             10'h124

// Programmed line and field lengths, actual minus one
`define LINE_MID          10'h19f
`define LINE_VGA          10'h2f9
`define LINE_QTR          10'h17c
`define FIELD_MID         10'h13f
`define FIELD_VGA         10'h20b
`define FIELD_QTR         10'h105

// Fixed VGA start, with 4 guard columns and 2 unread rows
`define VGA_X0            10'h005
`define VGA_Y0            10'h007

// Offset limits for the cropped formats
`define X_MIN             10'h001
`define Y_MIN             10'h005
`define MID_X_MAX         10'h129
`define MID_Y_MAX         10'h0c5
`define QTR_X_MAX         10'h149
`define QTR_Y_MAX         10'h0f5

// Centred start positions for the cropped formats
`define MID_X_CTR         10'h095
`define MID_Y_CTR         10'h067
`define QTR_X_CTR         10'h0a5
`define QTR_Y_CTR         10'h07f

// Reserved row ranges
`define BLACK_ROW_END     10'h005
`define DARK_ROW_START    10'h1ec

`endif

// File: hw/offset_limiter.v
// Clamps and clips the window start offsets for the selected format
`timescale 1ns/10ps
`default_nettype none
`include "pixel_readout_defines.vh"

module offset_limiter (
  input  wire [1:0] format,
  input  wire [9:0] xRequest,
  input  wire [9:0] yRequest,
  output reg  [9:0] xStart,
  output reg  [9:0] yStart
);

  reg [9:0] xMax;
  reg [9:0] yMax;

  ////////////////////////////////////////////////////////////////////////////
  // Limit selection and clamping
  always @* begin
    xMax = `QTR_X_MAX;
    yMax = `QTR_Y_MAX;
    if (format == `FMT_MID) begin
      xMax = `MID_X_MAX;
      yMax = `MID_Y_MAX;
    end
    if (format == `FMT_VGA || format == `FMT_DEC) begin
      xStart = `VGA_X0;
      yStart = `VGA_Y0;
    end else begin
      if (xRequest < `X_MIN)
        xStart = `X_MIN;
      else if (xRequest > xMax)
        xStart = xMax;
      else
        xStart = xRequest;
      if (yRequest < `Y_MIN)
        yStart = `Y_MIN;
      else if (yRequest > yMax)
        yStart = yMax;
      else
        yStart = yRequest;
    end
  end

endmodule // offset_limiter
`default_nettype wire

// File: hw/axis_order.v
// Maps a readout position to an axis index for shuffle, mirror, decimation
`timescale 1ns/10ps
`default_nettype none

module axis_order #(
  parameter WIDTH = 10
) (
  input  wire [WIDTH-1:0] position,
  input  wire [WIDTH-1:0] length,
  input  wire             shuffle,
  input  wire             mirror,
  input  wire             decimate,
  output reg  [WIDTH-1:0] index
);

  reg [WIDTH-1:0] half;
  reg [WIDTH-1:0] shuffled;
  reg [WIDTH-1:0] mirrored;

  ////////////////////////////////////////////////////////////////////////////
  // Odd zero-based first (even when counted from one), then reverse, then
  // spread groups of four over every second group of four
  always @* begin
    half = length >> 1;
    if (shuffle && position < half)
      shuffled = {position[WIDTH-2:0], 1'b1};
    else if (shuffle)
      shuffled = {position[WIDTH-2:0] - half[WIDTH-2:0], 1'b0};
    else
      shuffled = position;
    mirrored = mirror ? (length - shuffled - 1'b1) : shuffled;
    if (decimate)
      index = {mirrored[WIDTH-2:2], 1'b0, mirrored[1:0]};
    else
      index = mirrored;
  end

endmodule // axis_order
`default_nettype wire

// File: hw/pixel_readout.v
// Pixel array readout address generator with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "pixel_readout_defines.vh"

module pixel_readout #(
  parameter AW = 10
) (
  input  wire          clock,
  input  wire          reset,
  input  wire [AW-1:0] address,
  input  wire          read,
  input  wire          write,
  input  wire [3:0]    byteenable,
  input  wire [31:0]   writedata,
  output reg  [31:0]   readdata,
  output wire          waitrequest,
  output reg  [9:0]    colAddress,
  output reg  [9:0]    rowAddress,
  output reg           pixelValid,
  output reg           lineStart,
  output reg           frameStart
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg        ack_reg;
  reg [1:0]  format_reg;
  reg [7:0]  readoutA_reg;
  reg [7:0]  readoutB_reg;
  reg [9:0]  xRequest_reg;
  reg [9:0]  yRequest_reg;
  reg [9:0]  lineLen_reg;
  reg [9:0]  fieldLen_reg;
  reg [9:0]  hCount_reg;
  reg [9:0]  vCount_reg;
  reg [9:0]  hCount_next;
  reg [9:0]  vCount_next;
  reg [1:0]  frameFormat_reg;
  reg [9:0]  frameX_reg;
  reg [9:0]  frameY_reg;
  reg        frameHShuf_reg;
  reg        frameHMirr_reg;
  reg        frameVShuf_reg;
  reg        frameVMirr_reg;
  reg [9:0]  width;
  reg [9:0]  height;
  reg [9:0]  lineLenNew;
  reg [9:0]  fieldLenNew;
  reg [31:0] readValue;
  wire [7:0] index;
  wire       accept;
  wire       writeHit;
  wire       lineEnd;
  wire       frameEnd;
  wire       active;
  wire       decimate;
  wire [9:0] xStart;
  wire [9:0] yStart;
  wire [9:0] colIndex;
  wire [9:0] rowIndex;
  wire [1:0] newFormat;
  wire       newCropped;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon handshake: one wait cycle, then the request is taken
  assign index       = address[9:2];
  assign waitrequest = (read | write) & ~ack_reg;
  assign accept      = (read | write) & ack_reg;
  assign writeHit    = write & ack_reg;
  assign newFormat   = writedata[1:0];
  assign newCropped  = (newFormat == `FMT_MID) || (newFormat == `FMT_QTR);

  // Acknowledge toggles so a held request sees one wait cycle per transfer
  always @(posedge clock) begin
    if (reset)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read | write) & ~ack_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line and field lengths loaded whenever a format is written
  always @* begin
    case (newFormat)
      `FMT_MID: begin
        lineLenNew  = `LINE_MID;
        fieldLenNew = `FIELD_MID;
      end
      `FMT_VGA: begin
        lineLenNew  = `LINE_VGA;
        fieldLenNew = `FIELD_VGA;
      end
      default: begin
        lineLenNew  = `LINE_QTR;
        fieldLenNew = `FIELD_QTR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clock) begin
    if (reset) begin
      format_reg   <= `FMT_RESET;
      readoutA_reg <= `READOUT_A_RESET;
      readoutB_reg <= `READOUT_B_RESET;
      xRequest_reg <= `MID_X_CTR;
      yRequest_reg <= `MID_Y_CTR;
      lineLen_reg  <= `LINE_MID;
      fieldLen_reg <= `FIELD_MID;
    end else if (writeHit && byteenable[0]) begin
      case (index)
        `REG_FORMAT: begin
          format_reg   <= newFormat;
          lineLen_reg  <= lineLenNew;
          fieldLen_reg <= fieldLenNew;
          // Centre the window on entry to a cropped format
          if (newCropped && newFormat != format_reg) begin
            xRequest_reg <= (newFormat == `FMT_MID) ?
                            `MID_X_CTR : `QTR_X_CTR;
            yRequest_reg <= (newFormat == `FMT_MID) ?
                            `MID_Y_CTR : `QTR_Y_CTR;
          end
        end
        `REG_READOUT_A: readoutA_reg <= writedata[7:0];
        `REG_READOUT_B: readoutB_reg <= writedata[7:0];
        `REG_XOFF_HI:   xRequest_reg[9:8] <= writedata[1:0];
        `REG_XOFF_LO:   xRequest_reg[7:0] <= writedata[7:0];
        `REG_YOFF_HI:   yRequest_reg[9:8] <= writedata[1:0];
        `REG_YOFF_LO:   yRequest_reg[7:0] <= writedata[7:0];
        `REG_LINE_LEN: begin
          lineLen_reg[7:0] <= writedata[7:0];
          if (byteenable[1])
            lineLen_reg[9:8] <= writedata[9:8];
        end
        `REG_FIELD_LEN: begin
          fieldLen_reg[7:0] <= writedata[7:0];
          if (byteenable[1])
            fieldLen_reg[9:8] <= writedata[9:8];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped addresses read as zero
  always @* begin
    case (index)
      `REG_FORMAT:    readValue = {30'h00000000, format_reg};
      `REG_READOUT_A: readValue = {24'h000000, readoutA_reg};
      `REG_READOUT_B: readValue = {24'h000000, readoutB_reg};
      `REG_XOFF_HI:   readValue = {30'h00000000, xRequest_reg[9:8]};
      `REG_XOFF_LO:   readValue = {24'h000000, xRequest_reg[7:0]};
      `REG_YOFF_HI:   readValue = {30'h00000000, yRequest_reg[9:8]};
      `REG_YOFF_LO:   readValue = {24'h000000, yRequest_reg[7:0]};
      `REG_LINE_LEN:  readValue = {22'h000000, lineLen_reg};
      `REG_FIELD_LEN: readValue = {22'h000000, fieldLen_reg};
      `REG_STATUS:    readValue = {15'h0000, active, 6'h00, vCount_reg};
      default:        readValue = 32'h00000000;
    endcase
  end

  // Read data captured during the wait cycle, standing at the accept edge
  always @(posedge clock) begin
    if (reset)
      readdata <= 32'h00000000;
    else if (read && !ack_reg)
      readdata <= readValue;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Image size of the format latched for the current frame
  always @* begin
    case (frameFormat_reg)
      `FMT_MID: begin
        width  = `MID_W;
        height = `MID_H;
      end
      `FMT_VGA: begin
        width  = `VGA_W;
        height = `VGA_H;
      end
      default: begin
        width  = `QTR_W;
        height = `QTR_H;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line and field counters count from zero up to the programmed lengths
  assign lineEnd  = hCount_reg >= lineLen_reg;
  assign frameEnd = lineEnd && (vCount_reg >= fieldLen_reg);

  always @* begin
    hCount_next = hCount_reg + 10'h001;
    vCount_next = vCount_reg;
    if (lineEnd) begin
      hCount_next = 10'h000;
      vCount_next = frameEnd ? 10'h000 : vCount_reg + 10'h001;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      hCount_reg <= 10'h000;
      vCount_reg <= 10'h000;
    end else begin
      hCount_reg <= hCount_next;
      vCount_reg <= vCount_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window start after clamping and clipping
  offset_limiter limiter (
    .format   (format_reg),
    .xRequest (xRequest_reg),
    .yRequest (yRequest_reg),
    .xStart   (xStart),
    .yStart   (yStart)
  );

  // Format, offsets and options are held steady for a whole frame
  always @(posedge clock) begin
    if (reset) begin
      frameFormat_reg <= `FMT_RESET;
      frameX_reg      <= `MID_X_CTR;
      frameY_reg      <= `MID_Y_CTR;
      frameHShuf_reg  <= 1'b1;
      frameHMirr_reg  <= 1'b0;
      frameVShuf_reg  <= 1'b0;
      frameVMirr_reg  <= 1'b0;
    end else if (frameEnd) begin
      frameFormat_reg <= format_reg;
      frameX_reg      <= xStart;
      frameY_reg      <= yStart;
      frameHShuf_reg  <= readoutA_reg[`HSHUF_BIT];
      frameHMirr_reg  <= readoutB_reg[`HMIRR_BIT];
      frameVShuf_reg  <= readoutB_reg[`VSHUF_BIT];
      frameVMirr_reg  <= readoutB_reg[`VMIRR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout order along each axis
  assign decimate = frameFormat_reg == `FMT_DEC;

  axis_order #(
    .WIDTH (10)
  ) columnOrder (
    .position (hCount_reg),
    .length   (width),
    .shuffle  (frameHShuf_reg),
    .mirror   (frameHMirr_reg),
    .decimate (decimate),
    .index    (colIndex)
  );

  axis_order #(
    .WIDTH (10)
  ) rowOrder (
    .position (vCount_reg),
    .length   (height),
    .shuffle  (frameVShuf_reg),
    .mirror   (frameVMirr_reg),
    .decimate (decimate),
    .index    (rowIndex)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address outputs; only visible rows between black and dark ranges
  assign active = (hCount_reg < width) && (vCount_reg < height);

  always @(posedge clock) begin
    if (reset) begin
      colAddress <= 10'h000;
      rowAddress <= 10'h000;
      pixelValid <= 1'b0;
      lineStart  <= 1'b0;
      frameStart <= 1'b0;
    end else begin
      colAddress <= frameX_reg + colIndex;
      rowAddress <= frameY_reg + rowIndex;
      pixelValid <= active;
      lineStart  <= active && (hCount_reg == 10'h000);
      frameStart <= active && (hCount_reg == 10'h000) &&
                    (vCount_reg == 10'h000);
    end
  end

endmodule // pixel_readout
`default_nettype wire

// File: tb/pixel_readout_chk.sv
// Concurrent checks on the pixel readout ports
`timescale 1ns/10ps
`default_nettype none
`include "pixel_readout_defines.vh"

module pixel_readout_chk #(
  parameter AW = 10
) (
  input wire logic          clock,
  input wire logic          reset,
  input wire logic [AW-1:0] address,
  input wire logic          read,
  input wire logic          write,
  input wire logic [3:0]    byteenable,
  input wire logic [31:0]   writedata,
  input wire logic [31:0]   readdata,
  input wire logic          waitrequest,
  input wire logic [9:0]    colAddress,
  input wire logic [9:0]    rowAddress,
  input wire logic          pixelValid,
  input wire logic          lineStart,
  input wire logic          frameStart
);
  logic [9:0] runLen;
  logic [9:0] lineGap;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  ////////////////////////////////////////
  // Valid run length and clocks since the last line start
  always_ff @(posedge clock) begin
    if (reset) begin
      runLen  <= 10'h000;
      lineGap <= 10'h000;
    end else begin
      runLen  <= lineStart ? 10'h001 : runLen + {9'h000, pixelValid};
      lineGap <= lineStart ? 10'h001 : lineGap + 10'h001;
    end
  end

  ////////////////////////////////////////
  // Steps of a bus access and of a line
  sequence reqPending;
    (read || write) && waitrequest;
  endsequence
  sequence lineOpen;
    pixelValid && !lineStart;
  endsequence

  ////////////////////////////////////////
  // Bus and stream relations
  wait_one_a: assert property (reqPending |=> !waitrequest)
    else $error("bus request kept waiting past one cycle");
  row_range_a: assert property (pixelValid |->
    rowAddress >= `BLACK_ROW_END && rowAddress <= `DARK_ROW_START)
    else $error("visible pixel on a black or dark row");
  col_range_a: assert property (pixelValid |->
    colAddress >= 10'h001 && colAddress <= 10'h28c)
    else $error("column outside the physical array");
  start_valid_a: assert property (lineStart |-> pixelValid)
    else $error("line start without a pixel");
  frame_line_a: assert property (frameStart |-> lineStart)
    else $error("frame start not on a line start");
  valid_lead_a: assert property ($rose(pixelValid) |-> lineStart)
    else $error("pixel run began without a line start");
  run_width_a: assert property ($fell(pixelValid) |->
    runLen inside {`MID_W, `VGA_W, `QTR_W})
    else $error("line width not a format width");
  line_gap_a: assert property (lineStart && !frameStart |->
    lineGap >= 10'h17d)
    else $error("line shorter than any line length");
  row_hold_a: assert property (lineOpen |-> $stable(rowAddress))
    else $error("row changed inside a line");
  col_move_a: assert property (lineOpen |->
    colAddress != $past(colAddress))
    else $error("column did not advance");
endmodule // pixel_readout_chk

bind pixel_readout pixel_readout_chk #(.AW(AW)) i_chk (
  .clock(clock), .reset(reset), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .colAddress(colAddress), .rowAddress(rowAddress),
  .pixelValid(pixelValid), .lineStart(lineStart), .frameStart(frameStart)
);
`default_nettype wire

// File: tb/video_sink.sv
// Behavioural video coprocessor absorbing the pixel stream
`timescale 1ns/10ps
`default_nettype none

module video_sink (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       pixelValid,
  input  wire logic       lineStart,
  input  wire logic       frameStart,
  output var  logic [9:0] lastRun,
  output var  logic [9:0] lineCount
);
  logic [9:0] run;

  ////////////////////////////////////////
  // Counts pixels of each line and lines of each frame
  always @(posedge clock) begin
    if (reset) begin
      run       <= 10'h000;
      lastRun   <= 10'h000;
      lineCount <= 10'h000;
    end else begin
      if (pixelValid) begin
        run <= lineStart ? 10'h001 : run + 10'h001;
      end else if (run != 10'h000) begin
        lastRun <= run;
        run     <= 10'h000;
      end
      if (lineStart) begin
        lineCount <= frameStart ? 10'h001 : lineCount + 10'h001;
      end
    end
  end
endmodule // video_sink
`default_nettype wire

// File: tb/pixel_readout_test.sv
// Self-checking bench for the pixel readout address generator
`timescale 1ns/10ps
`default_nettype none
`include "pixel_readout_defines.vh"

module pixel_readout_test;
  logic        clock = 1'b0;
  logic        reset;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [9:0]  colAddress;
  logic [9:0]  rowAddress;
  logic        pixelValid;
  logic        lineStart;
  logic        frameStart;
  logic [9:0]  lastRun;
  logic [9:0]  lineCount;
  int          nMismatch;
  int          comparisons;
  int          cycles;

  pixel_readout #(.AW(10)) i_dut (
    .clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .colAddress(colAddress), .rowAddress(rowAddress),
    .pixelValid(pixelValid), .lineStart(lineStart), .frameStart(frameStart)
  );

  video_sink i_sink (
    .clock(clock), .reset(reset), .pixelValid(pixelValid),
    .lineStart(lineStart), .frameStart(frameStart),
    .lastRun(lastRun), .lineCount(lineCount)
  );

  ////////////////////////////////////////
  // Clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin // Short frames need about 19000 clocks
      nMismatch++;
      stop_test();
    end
  end

  ////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [3:0] be, input logic [31:0] data,
                     output logic [31:0] rdata);
    @(posedge clock);
    address    <= {idx, 2'b00};
    read       <= !wr;
    write      <= wr;
    byteenable <= be;
    writedata  <= data;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rdata = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [3:0] be,
                    input logic [31:0] data);
    logic [31:0] d;
    bus(1'b1, idx, be, data, d);
  endtask

  task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 4'hf, 32'h0, d);
    check(d, exp);
  endtask

  // Shuffled position over the cropped mid width, half is 178
  function automatic logic [9:0] shuf(input int p);
    if (p < 178) shuf = 10'(2 * p + 1);
    else shuf = 10'(2 * (p - 178));
  endfunction

  ////////////////////////////////////////
  // Scenarios
  task automatic test_first_line();
    int k;
    k = 0;
    @(negedge clock);
    while (pixelValid !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    check({31'h0, frameStart}, 32'h1);
    check({31'h0, lineStart}, 32'h1);
    check({22'h0, rowAddress}, {22'h0, `MID_Y_CTR});
    for (k = 0; k < 356; k++) begin
      check({21'h0, pixelValid, colAddress},
            {22'h1, `MID_X_CTR + shuf(k)});
      @(negedge clock);
    end
    for (k = 0; k < 60; k++) begin
      check({31'h0, pixelValid}, 32'h0);
      @(negedge clock);
    end
    check({30'h0, lineStart, frameStart}, 32'h2);
    check({22'h0, rowAddress}, {22'h0, `MID_Y_CTR + 10'h001});
    check({22'h0, colAddress}, {22'h0, `MID_X_CTR + 10'h001});
    check({22'h0, lastRun}, 32'h164);
  endtask

  task automatic test_reset_regs();
    logic [7:0]  ix [9] = '{8'h10, 8'h11, 8'h16, 8'h58, 8'h59, 8'h5a,
                            8'h5b, 8'h60, 8'h61};
    logic [31:0] ex [9] = '{32'h0, 32'h80, 32'h0, 32'h0, 32'h95, 32'h0,
                            32'h67, 32'h19f, 32'h13f};
    for (int i = 0; i < 9; i++) rd_check(ix[i], ex[i]);
  endtask

  task automatic test_reg_access();
    wr(`REG_XOFF_LO, 4'hf, 32'h33);
    rd_check(`REG_XOFF_LO, 32'h33);
    wr(`REG_YOFF_LO, 4'h1, 32'h31);
    rd_check(`REG_YOFF_LO, 32'h31);
    wr(`REG_READOUT_A, 4'he, 32'h0);
    rd_check(`REG_READOUT_A, 32'h80);
    wr(`REG_READOUT_B, 4'h1, 32'h1c);
    rd_check(`REG_READOUT_B, 32'h1c);
    wr(8'h20, 4'hf, 32'hff);
    rd_check(8'h20, 32'h0);
  endtask

  task automatic test_format_lengths();
    logic [31:0] fm [4] = '{32'h1, 32'h2, 32'h3, 32'h0};
    logic [31:0] ln [4] = '{32'h2f9, 32'h17c, 32'h17c, 32'h19f};
    logic [31:0] fl [4] = '{32'h20b, 32'h105, 32'h105, 32'h13f};
    for (int i = 0; i < 4; i++) begin
      wr(`REG_FORMAT, 4'h1, fm[i]);
      rd_check(`REG_FORMAT, fm[i]);
      rd_check(`REG_LINE_LEN, ln[i]);
      rd_check(`REG_FIELD_LEN, fl[i]);
    end
  endtask

  // Waits for the second frame start so new settings are latched, then checks the
  // first two pixels, the line count of the last frame and the second row
  task automatic frame_check(input logic [9:0] c0, c1, r0, r1);
    repeat (2) begin
      @(negedge clock);
      while (frameStart !== 1'b1) @(negedge clock);
    end
    check({22'h0, lineCount}, 32'h4);
    check({12'h0, rowAddress, colAddress}, {12'h0, r0, c0});
    @(negedge clock);
    check({21'h0, pixelValid, colAddress}, {22'h1, c1});
    @(negedge clock);
    while (lineStart !== 1'b1) @(negedge clock);
    check({12'h0, rowAddress, colAddress}, {12'h0, r1, c0});
  endtask

  // All four order options together in cropped mid, window centred
  task automatic test_combined_order();
    wr(`REG_FIELD_LEN, 4'h3, 32'h3);
    wr(`REG_READOUT_B, 4'h1, 32'h1c);
    frame_check(10'h1f7, 10'h1f5, 10'h189, 10'h187);
  endtask

  // Plain raster in cropped mid with both offsets out of range
  task automatic test_mid_clip();
    wr(`REG_READOUT_A, 4'h1, 32'h0);
    wr(`REG_READOUT_B, 4'h1, 32'h0);
    wr(`REG_XOFF_HI, 4'h1, 32'h3);
    wr(`REG_XOFF_LO, 4'h1, 32'hff);
    wr(`REG_YOFF_LO, 4'h1, 32'h0);
    frame_check(10'h129, 10'h12a, 10'h005, 10'h006);
  endtask

  // Cropped quarter: centred on entry, then clamped and clipped offsets
  task automatic test_quarter_clamp();
    wr(`REG_FORMAT, 4'h1, 32'h2);
    rd_check(`REG_XOFF_LO, 32'ha5);
    rd_check(`REG_YOFF_LO, 32'h7f);
    wr(`REG_FIELD_LEN, 4'h3, 32'h3);
    wr(`REG_READOUT_A, 4'h1, 32'h80);
    wr(`REG_READOUT_B, 4'h1, 32'h04);
    wr(`REG_XOFF_LO, 4'h1, 32'h0);
    wr(`REG_YOFF_HI, 4'h1, 32'h1);
    wr(`REG_YOFF_LO, 4'h1, 32'hff);
    frame_check(10'h002, 10'h004, 10'h0f6, 10'h0f8);
  endtask

  // Decimated quarter with both mirrors: fixed offsets, groups of four
  task automatic test_decimated();
    wr(`REG_FORMAT, 4'h1, 32'h3);
    wr(`REG_FIELD_LEN, 4'h3, 32'h3);
    wr(`REG_READOUT_A, 4'h1, 32'h0);
    wr(`REG_READOUT_B, 4'h1, 32'h18);
    frame_check(10'h288, 10'h287, 10'h1ea, 10'h1e9);
  endtask

  // VGA with horizontal shuffle; runs last, its long lines never shrink
  task automatic test_vga_fixed();
    wr(`REG_FORMAT, 4'h1, 32'h1);
    wr(`REG_FIELD_LEN, 4'h3, 32'h3);
    wr(`REG_READOUT_A, 4'h1, 32'h80);
    wr(`REG_READOUT_B, 4'h1, 32'h0);
    frame_check(10'h006, 10'h008, 10'h007, 10'h008);
  endtask

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    reset       = 1'b1;
    address     = 10'h000;
    read        = 1'b0;
    write       = 1'b0;
    byteenable  = 4'h0;
    writedata   = 32'h0;
    nMismatch   = 0;
    comparisons = 0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    test_first_line();
    test_reset_regs();
    test_reg_access();
    test_format_lengths();
    test_combined_order();
    test_mid_clip();
    test_quarter_clamp();
    test_decimated();
    test_vga_fixed();
    stop_test();
  end
endmodule // pixel_readout_test
`default_nettype wire
